// File: logic/fpm_pkg.sv
// Constants, field layouts and carrier types for the flash page map block.
// Assumes a 16-bit CPU address bus and an 8-bit page select value.
// Behaviour
// [RULE1] Logical 0x4000-0xFFFF decodes as three flash windows
// [RULE2] Middle window follows the page select value
// [RULE3] Block address is page number over offset
// [RULE4] Page values 0x38-0x3F select pages 0-7
// [RULE5] Unpaged windows fixed to pages 0x3E, 0x3F
// [RULE6] Protection register can protect whole block
// [RULE7] Lower region grows up 1-8 Kbyte
// [RULE8] Higher region grows down 2-16 Kbyte
// [RULE9] Remaining region has independent protection
// [RULE10] Backdoor key at 0xFF00-0xFF07 and alias
// [RULE11] Protection byte at 0xFF0D and alias
// [RULE12] Security byte 0xFF0F; 0xFF08-0C, 0xFF0E reserved
// [RULE13] Sixteen byte registers at offsets 0x0-0xF
// [RULE14] Security register read-only
// [RULE15] Address and data holding registers read-only
// [RULE16] Offsets 0x7, 0xC-0xF factory test, read-only
// [RULE17] Security register loaded from flash at reset
// [RULE18] Writes to read-only offsets ignored, answered OKAY
package fpm_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [3:0] IDX_CLKDIV = 4'h0;
    localparam logic [3:0] IDX_SEC = 4'h1;
    localparam logic [3:0] IDX_TSTMOD = 4'h2;
    localparam logic [3:0] IDX_CNFG = 4'h3;
    localparam logic [3:0] IDX_PROT = 4'h4;
    localparam logic [3:0] IDX_STAT = 4'h5;
    localparam logic [3:0] IDX_CMD = 4'h6;
    localparam logic [3:0] IDX_ADDRHI = 4'h8;
    localparam logic [3:0] IDX_ADDRLO = 4'h9;
    localparam logic [3:0] IDX_DATAHI = 4'ha;
    localparam logic [3:0] IDX_DATALO = 4'hb;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] PROT_RST = 8'hff;
    localparam logic [7:0] SEC_FAULT = 8'hff;
    // Windows and pages
    localparam logic [1:0] WIN_NONE = 2'h0;
    localparam logic [1:0] WIN_LOW = 2'h1;
    localparam logic [1:0] WIN_PAGED = 2'h2;
    localparam logic [7:0] PG_LOW_FIXED = 8'h3e;
    localparam logic [7:0] PG_HIGH_FIXED = 8'h3f;
    localparam logic [4:0] PG_BASE_HI = 5'h07;
    localparam logic [2:0] PHYS_LOWER = 3'h6;
    localparam logic [2:0] PHYS_HIGHER = 3'h7;
    // Region sizes: lower 1 Kbyte << size, higher 2 Kbyte << size
    localparam logic [14:0] LOW_UNIT = 15'h0400;
    localparam logic [14:0] HIGH_UNIT = 15'h0800;
    localparam logic [14:0] WIN_SIZE = 15'h4000;
    // Configuration field, as offsets within the last page; CFG_SEC_BLK as a block address
    localparam logic [9:0] CFG_ROW = 10'h3f0;
    localparam logic [3:0] CFG_PROT = 4'hd;
    localparam logic [3:0] CFG_SEC = 4'hf;
    localparam logic [16:0] CFG_SEC_BLK = 17'h1ff0f;
    // Protection register fields
    localparam int PR_OPEN = 7;
    localparam int PR_OTHER = 6;
    localparam int PR_HDIS = 5;
    localparam int PR_LDIS = 2;

    typedef struct packed {
        logic hit;
        logic [16:0] blk_addr;
        logic low;
        logic high;
        logic other;
        logic wr_block;
        logic key;
        logic [2:0] key_idx;
        logic prot_byte;
        logic sec_byte;
        logic rsvd_byte;
    } fpm_dec_t;
endpackage

// File: logic/fpm_top.sv
// Flash page map, protection region decode and control register file.
// Assumes an AXI4-Lite master, a CPU bus synchronous to ref_clk and a
// flash read port that answers the reset-time security load.
`timescale 1ns/100ps
module fpm_top import fpm_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // AXI4-Lite slave
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // CPU bus
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_valid,
    input wire logic cpu_write,
    input wire logic [15:0] cpu_wdata,
    input wire logic [7:0] page_select_value,
    output fpm_dec_t dec_ff,
    // Reset-time flash read
    output logic ld_req,
    output logic [16:0] ld_addr,
    input wire logic ld_valid,
    input wire logic [7:0] ld_data,
    input wire logic ld_fault
);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        LD_IDLE = 3'b001,
        LD_WAIT = 3'b010,
        LD_RUN = 3'b100
    } fpm_ld_t;

    logic rst_meta_ff;
    logic rst_n_ff;
    fpm_ld_t ld_ff;
    fpm_ld_t nxt_ld;
    logic [7:0] clkdiv_ff;
    logic [7:0] sec_ff;
    logic [7:0] tstmod_ff;
    logic [7:0] cnfg_ff;
    logic [7:0] prot_ff;
    logic [7:0] stat_ff;
    logic [7:0] cmd_ff;
    logic [15:0] hold_addr_ff;
    logic [15:0] hold_data_ff;
    fpm_dec_t nxt_dec;
    logic [7:0] phys_pg;
    logic [14:0] off;
    logic wr_go;
    logic [3:0] wr_idx;
    logic [3:0] rd_idx;
    logic [7:0] rd_byte;
    logic wr_map;
    logic rd_map;

    // Reset released through two flops so the release is clean
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // Address decode
    always_comb begin
        nxt_dec = '0;
        off = {1'b0, cpu_addr[13:0]};
        unique case (cpu_addr[15:14])
            WIN_LOW: phys_pg = PG_LOW_FIXED; // [RULE5]
            WIN_PAGED: phys_pg = page_select_value; // [RULE2]
            default: phys_pg = PG_HIGH_FIXED; // [RULE5]
        endcase
        nxt_dec.hit = cpu_valid && (cpu_addr[15:14] != WIN_NONE)
            && (phys_pg[7:3] == PG_BASE_HI); // [RULE1] [RULE4]
        nxt_dec.blk_addr = {phys_pg[2:0], cpu_addr[13:0]}; // [RULE3] [RULE4]
        nxt_dec.low = nxt_dec.hit && (phys_pg[2:0] == PHYS_LOWER)
            && (off < (LOW_UNIT << prot_ff[1:0])); // [RULE7]
        nxt_dec.high = nxt_dec.hit && (phys_pg[2:0] == PHYS_HIGHER)
            && (off >= WIN_SIZE - (HIGH_UNIT << prot_ff[4:3])); // [RULE8]
        nxt_dec.other = nxt_dec.hit && !nxt_dec.low && !nxt_dec.high; // [RULE9]
        // Whole-block protection overrides the per-region enables
        nxt_dec.wr_block = nxt_dec.hit && (!prot_ff[PR_OPEN]
            || (nxt_dec.low && !prot_ff[PR_LDIS])
            || (nxt_dec.high && !prot_ff[PR_HDIS])
            || (nxt_dec.other && prot_ff[PR_OTHER])); // [RULE6] [RULE9]
        if (nxt_dec.hit && phys_pg[2:0] == PHYS_HIGHER && cpu_addr[13:4] == CFG_ROW) begin
            nxt_dec.key = !cpu_addr[3]; // [RULE10]
            nxt_dec.key_idx = cpu_addr[2:0]; // [RULE10]
            nxt_dec.prot_byte = cpu_addr[3:0] == CFG_PROT; // [RULE11]
            nxt_dec.sec_byte = cpu_addr[3:0] == CFG_SEC; // [RULE12]
            nxt_dec.rsvd_byte = cpu_addr[3] && !nxt_dec.prot_byte
                && !nxt_dec.sec_byte; // [RULE12]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            dec_ff <= '0;
        end else begin
            dec_ff <= nxt_dec;
        end
    end

    // Holding registers capture the last CPU write into the flash block
    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            hold_addr_ff <= '0;
            hold_data_ff <= '0;
        end else if (nxt_dec.hit && cpu_write) begin
            hold_addr_ff <= nxt_dec.blk_addr[16:1];
            hold_data_ff <= cpu_wdata;
        end
    end

    // Security load sequence after reset release
    always_comb begin
        nxt_ld = ld_ff;
        unique case (ld_ff)
            LD_IDLE: nxt_ld = LD_WAIT;
            LD_WAIT: if (ld_valid) nxt_ld = LD_RUN;
            LD_RUN: nxt_ld = LD_RUN;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ld_ff <= LD_IDLE;
        end else begin
            ld_ff <= nxt_ld;
        end
    end

    assign ld_req = (ld_ff == LD_WAIT);
    assign ld_addr = CFG_SEC_BLK; // [RULE17]

    // A double fault on the load leaves the part secured, keys disabled
    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            sec_ff <= SEC_FAULT;
        end else if (ld_ff == LD_WAIT && ld_valid) begin
            sec_ff <= ld_fault ? SEC_FAULT : ld_data; // [RULE17]
        end
    end

    // AXI4-Lite write: address and data are taken together
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign wr_idx = s_axi_awaddr[5:2];
    assign wr_map = (s_axi_awaddr[1:0] == 2'h0); // [RULE13]

    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR; // [RULE18]
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Only the read/write offsets take bus writes; the rest ignore writes
    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            clkdiv_ff <= REG_RST;
            tstmod_ff <= REG_RST;
            cnfg_ff <= REG_RST;
            prot_ff <= PROT_RST;
            stat_ff <= REG_RST;
            cmd_ff <= REG_RST;
        end else if (wr_go && wr_map && s_axi_wstrb[0]) begin
            unique case (wr_idx)
                IDX_CLKDIV: clkdiv_ff <= s_axi_wdata[7:0];
                IDX_TSTMOD: tstmod_ff <= s_axi_wdata[7:0];
                IDX_CNFG: cnfg_ff <= s_axi_wdata[7:0];
                IDX_PROT: prot_ff <= s_axi_wdata[7:0];
                IDX_STAT: stat_ff <= s_axi_wdata[7:0];
                IDX_CMD: cmd_ff <= s_axi_wdata[7:0];
                default: ; // [RULE14] [RULE15] [RULE16] [RULE18]
            endcase
        end
    end

    // AXI4-Lite read
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx = s_axi_araddr[5:2];
    assign rd_map = (s_axi_araddr[1:0] == 2'h0);

    always_comb begin
        unique case (rd_idx)
            IDX_CLKDIV: rd_byte = clkdiv_ff;
            IDX_SEC: rd_byte = sec_ff;
            IDX_TSTMOD: rd_byte = tstmod_ff;
            IDX_CNFG: rd_byte = cnfg_ff;
            IDX_PROT: rd_byte = prot_ff;
            IDX_STAT: rd_byte = stat_ff;
            IDX_CMD: rd_byte = cmd_ff;
            IDX_ADDRHI: rd_byte = hold_addr_ff[15:8];
            IDX_ADDRLO: rd_byte = hold_addr_ff[7:0];
            IDX_DATAHI: rd_byte = hold_data_ff[15:8];
            IDX_DATALO: rd_byte = hold_data_ff[7:0];
            default: rd_byte = REG_RST; // [RULE16]
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_map ? rd_byte : REG_RST}; // [RULE13]
            s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    a_window_hit: assert property (@(posedge ref_clk) disable iff (!rst_n_ff) // [RULE1]
        cpu_valid && cpu_addr[15:14] == WIN_LOW |=> dec_ff.hit)
        else $error("unpaged low window not decoded");
    a_paged_map: assert property (@(posedge ref_clk) disable iff (!rst_n_ff) // [RULE2]
        cpu_valid && cpu_addr[15:14] == WIN_PAGED && page_select_value == 8'h39
        |=> dec_ff.hit && dec_ff.blk_addr[16:14] == 3'h1)
        else $error("paged window maps to wrong page");
    a_blk_offset: assert property (@(posedge ref_clk) disable iff (!rst_n_ff) // [RULE3]
        dec_ff.hit |-> dec_ff.blk_addr[13:0] == $past(cpu_addr[13:0]))
        else $error("block offset differs from CPU offset");
    a_page_range: assert property (@(posedge ref_clk) disable iff (!rst_n_ff) // [RULE4]
        cpu_addr[15:14] == WIN_PAGED && page_select_value < 8'h38 |=> !dec_ff.hit)
        else $error("page value below range decoded");
    a_fixed_high: assert property (@(posedge ref_clk) disable iff (!rst_n_ff) // [RULE5]
        cpu_valid && cpu_addr[15:14] == 2'h3 |=> dec_ff.blk_addr[16:14] == PHYS_HIGHER)
        else $error("top window not on last page");
    a_prot_all: assert property (@(posedge ref_clk) disable iff (!rst_n_ff) // [RULE6]
        nxt_dec.hit && !prot_ff[PR_OPEN] |=> dec_ff.wr_block)
        else $error("whole-block protection not applied");
    a_low_edge: assert property (@(posedge ref_clk) disable iff (!rst_n_ff) // [RULE7]
        cpu_valid && cpu_addr == 16'h4400 && prot_ff[1:0] == 2'h0 |=> !dec_ff.low)
        else $error("lower region too large");
    a_high_edge: assert property (@(posedge ref_clk) disable iff (!rst_n_ff) // [RULE8]
        cpu_valid && cpu_addr == 16'hf800 && prot_ff[4:3] == 2'h0 |=> dec_ff.high)
        else $error("higher region start wrong");
    a_sec_byte: assert property (@(posedge ref_clk) disable iff (!rst_n_ff) // [RULE12]
        cpu_valid && cpu_addr == 16'hff0f |=> dec_ff.sec_byte && !dec_ff.rsvd_byte)
        else $error("security byte not flagged");
    a_sec_load: assert property (@(posedge ref_clk) disable iff (!rst_n_ff) // [RULE17]
        ld_req && ld_valid && !ld_fault |=> sec_ff == $past(ld_data) ##1 !ld_req)
        else $error("security byte not loaded");
    a_sec_ro: assert property (@(posedge ref_clk) disable iff (!rst_n_ff) // [RULE14]
        ld_ff == LD_RUN && $past(ld_ff) == LD_RUN |-> $stable(sec_ff))
        else $error("security register changed after load");
endmodule // fpm_top

// File: test/fpm_cpu_model.sv
// CPU bus model: page select register, bus cycles, reset-time flash read.
// Assumes fpm_top samples the CPU bus at every rising ref_clk.
`timescale 1ns/100ps
module fpm_cpu_model import fpm_pkg::*; #(
    parameter logic [7:0] SEC_VAL = 8'h5a,
    parameter int LD_WAIT = 3
) (
    // Clock
    input wire logic ref_clk,
    // CPU bus
    output logic [15:0] cpu_addr,
    output logic cpu_valid,
    output logic cpu_write,
    output logic [15:0] cpu_wdata,
    output logic [7:0] page_select_value,
    // Reset-time flash read
    input wire logic ld_req,
    output logic ld_valid,
    output logic [7:0] ld_data,
    output logic ld_fault
);
    int wait_cnt = 0;
    // The second load reports a double fault so the secured fallback is exercised
    int n_loads = 0;
    initial begin
        cpu_addr = 16'h0000;
        cpu_valid = 1'b0;
        cpu_write = 1'b0;
        cpu_wdata = 16'h0000;
        page_select_value = 8'h38;
        ld_valid = 1'b0;
        ld_data = 8'h00;
        ld_fault = 1'b0;
    end
    // One bus cycle; the address is scrambled afterwards so stale values never match
    task automatic access(input logic [7:0] pg, input logic [15:0] a);
        @(posedge ref_clk);
        page_select_value <= pg;
        cpu_addr <= a;
        cpu_valid <= 1'b1;
        cpu_wdata <= ~a;
        @(posedge ref_clk);
        cpu_valid <= 1'b0;
        cpu_addr <= ~a;
    endtask
    // One CPU write cycle into the flash window
    task automatic store(input logic [7:0] pg, input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        page_select_value <= pg;
        cpu_addr <= a;
        cpu_valid <= 1'b1;
        cpu_write <= 1'b1;
        cpu_wdata <= d;
        @(posedge ref_clk);
        cpu_valid <= 1'b0;
        cpu_write <= 1'b0;
        cpu_addr <= ~a;
    endtask
    // Slow answer to the load; data toggles whenever it is not valid
    always @(posedge ref_clk) begin
        if (ld_req && !ld_valid && wait_cnt == LD_WAIT) begin
            ld_valid <= 1'b1;
            ld_data <= SEC_VAL;
            ld_fault <= (n_loads == 1);
            n_loads <= n_loads + 1;
        end else begin
            ld_valid <= 1'b0;
            ld_data <= ~ld_data;
            ld_fault <= 1'b0;
        end
        wait_cnt <= (ld_req && !ld_valid) ? wait_cnt + 1 : 0;
    end
endmodule // fpm_cpu_model

// File: test/fpm_top_tb.sv
// Self-checking bench for fpm_top: register file over AXI4-Lite, page map,
// protection regions and configuration field decode. Needs fpm_pkg and fpm_cpu_model.
`timescale 1ns/100ps
module fpm_top_tb import fpm_pkg::*;;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] cpu_addr, cpu_wdata;
    logic cpu_valid, cpu_write, ld_req, ld_valid, ld_fault;
    logic [7:0] page_select_value, ld_data;
    logic [16:0] ld_addr;
    logic [31:0] rd, rd0;
    fpm_dec_t dec;
    int fail_count = 0;
    int n_tests = 0;
    always #50 ref_clk = ~ref_clk;
    fpm_top fpm_top_i (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_addr, .cpu_valid, .cpu_write,
        .cpu_wdata, .page_select_value, .dec_ff(dec), .ld_req, .ld_addr, .ld_valid,
        .ld_data, .ld_fault);
    fpm_cpu_model fpm_cpu_model_i (.ref_clk, .cpu_addr, .cpu_valid, .cpu_write, .cpu_wdata,
        .page_select_value, .ld_req, .ld_valid, .ld_data, .ld_fault);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Handshakes are judged at the rising edge, before that edge's updates land
    task automatic axi_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do begin
            @(posedge ref_clk);
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge ref_clk);
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Read-only places keep their value when written, and still answer OKAY
    task automatic t_regs();
        logic [3:0] ro[10] = '{4'h1, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
        check({15'h0, ld_addr}, 32'h0001ff0f);
        axi_rd({IDX_SEC, 2'b00}, rd);
        check(rd, {24'h0, 8'h5a});
        axi_rd({IDX_PROT, 2'b00}, rd);
        check(rd, {24'h0, PROT_RST});
        axi_wr({IDX_CLKDIV, 2'b00}, 8'h3c);
        axi_rd({IDX_CLKDIV, 2'b00}, rd);
        check(rd, 32'h0000003c);
        // A CPU store fills the holding registers with word address and data
        fpm_cpu_model_i.store(8'h3d, 16'h9246, 16'hbeef);
        axi_rd({IDX_ADDRHI, 2'b00}, rd);
        check(rd, 32'h000000a9);
        axi_rd({IDX_ADDRLO, 2'b00}, rd);
        check(rd, 32'h00000023);
        axi_rd({IDX_DATAHI, 2'b00}, rd);
        check(rd, 32'h000000be);
        axi_rd({IDX_DATALO, 2'b00}, rd);
        check(rd, 32'h000000ef);
        foreach (ro[i]) begin
            axi_rd({ro[i], 2'b00}, rd0);
            axi_wr({ro[i], 2'b00}, ~rd0[7:0]);
            check({30'h0, resp}, 32'h0);
            axi_rd({ro[i], 2'b00}, rd);
            check(rd, rd0);
        end
        axi_wr(6'h11, 8'h00);
        check({30'h0, resp}, 32'h2);
        axi_rd(6'h12, rd);
        check({30'h0, resp}, 32'h2);
        check(rd, 32'h0);
    endtask
    task automatic map1(input logic [7:0] pg, input logic [15:0] a, input logic [17:0] exp);
        fpm_cpu_model_i.access(pg, a);
        #1 check({dec.hit, dec.blk_addr}, exp);
    endtask
    task automatic t_map();
        fpm_cpu_model_i.access(8'h38, 16'h3fff);
        #1 check({31'h0, dec.hit}, 32'h0);
        map1(8'h39, 16'h8000, 18'h24000);
        fpm_cpu_model_i.access(8'h37, 16'h8000);
        #1 check({31'h0, dec.hit}, 32'h0);
        fpm_cpu_model_i.access(8'h40, 16'hbfff);
        #1 check({31'h0, dec.hit}, 32'h0);
        map1(8'h38, 16'h4000, 18'h38000);
        map1(8'h3a, 16'h7fff, 18'h3bfff);
        map1(8'h38, 16'h8000, 18'h20000);
        map1(8'h3a, 16'h8123, 18'h28123);
        map1(8'h3d, 16'hbfff, 18'h37fff);
        map1(8'h3e, 16'h9000, 18'h39000);
        map1(8'h38, 16'hc000, 18'h3c000);
        map1(8'h3f, 16'hffff, 18'h3ffff);
    endtask
    // Flags {low, high, other, wr_block}
    task automatic reg1(input logic [7:0] pg, input logic [15:0] a, input logic [3:0] exp);
        fpm_cpu_model_i.access(pg, a);
        #1 check({28'h0, dec.low, dec.high, dec.other, dec.wr_block}, {28'h0, exp});
    endtask
    task automatic t_prot();
        axi_wr({IDX_PROT, 2'b00}, 8'ha1);
        reg1(8'h38, 16'h47ff, 4'b1001);
        reg1(8'h38, 16'h4800, 4'b0010);
        reg1(8'h3e, 16'h87ff, 4'b1001);
        reg1(8'h38, 16'hf800, 4'b0100);
        reg1(8'h38, 16'hf7ff, 4'b0010);
        axi_wr({IDX_PROT, 2'b00}, 8'hd4);
        reg1(8'h38, 16'h43ff, 4'b1000);
        reg1(8'h38, 16'h4400, 4'b0011);
        reg1(8'h38, 16'he000, 4'b0101);
        reg1(8'h38, 16'hdfff, 4'b0011);
        reg1(8'h3f, 16'ha000, 4'b0101);
        axi_wr({IDX_PROT, 2'b00}, 8'h24);
        reg1(8'h38, 16'h8000, 4'b0011);
    endtask
    // Flags {key, key_idx, prot_byte, sec_byte, rsvd_byte}
    task automatic cfg1(input logic [7:0] pg, input logic [15:0] a, input logic [6:0] exp);
        fpm_cpu_model_i.access(pg, a);
        #1 check({25'h0, dec.key, dec.key_idx, dec.prot_byte, dec.sec_byte,
            dec.rsvd_byte}, {25'h0, exp});
    endtask
    // The key index follows the low address bits across the whole field row
    task automatic t_cfg();
        cfg1(8'h38, 16'hff03, 7'b1011000);
        cfg1(8'h3f, 16'hbf07, 7'b1111000);
        cfg1(8'h38, 16'hff0d, 7'b0101100);
        cfg1(8'h3f, 16'hbf0f, 7'b0111010);
        cfg1(8'h38, 16'hff0f, 7'b0111010);
        cfg1(8'h3e, 16'hbf0f, 7'b0000000);
        cfg1(8'h38, 16'hff0e, 7'b0110001);
        cfg1(8'h38, 16'hff08, 7'b0000001);
    endtask
    // A second reset whose security load reports a double fault
    task automatic t_fault();
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (20) @(posedge ref_clk);
        axi_rd({IDX_SEC, 2'b00}, rd);
        check(rd, {24'h0, SEC_FAULT});
        axi_rd({IDX_PROT, 2'b00}, rd);
        check(rd, {24'h0, PROT_RST});
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        // Loader answers slowly; the security read waits for it
        repeat (20) @(posedge ref_clk);
        t_regs();
        t_map();
        t_prot();
        t_cfg();
        t_fault();
        tally_and_finish();
    end
    initial begin
        #2000000;
        fail_count++;
        tally_and_finish();
    end
endmodule // fpm_top_tb
